// [core/pm_control_and_timeout_timer.v]
/*
 Power-management control registers behind an index/data pair, with
 tristate overrides, clock source and gating controls, and a minute time-out
 timer reloaded by enabled interrupt lines.
 Assumes all inputs synchronous to ref_clk; IRQ inputs are active-high levels
 already normalised from their configured polarity.
*/
`include "pm_ctrl_regs.vh"

module pm_control_and_timeout_timer #(
   parameter CNT_W = 40,
   parameter [CNT_W-1:0] MINUTE_CYCLES = `MINUTE_CYCLES
) (
   input wire ref_clk,
   input wire resetn,
   input wire softReset,
   input wire pmActivate,
   input wire clock_strap,
   input wire busCs,
   input wire busAddr,
   input wire busRd,
   input wire busWr,
   input wire [7:0] busWrData,
   output reg [7:0] busRdData,
   input wire kbdTriCfg,
   input wire fdcTriCfg,
   input wire ppTriCfg,
   input wire uart2TriCfg,
   input wire uart1TriCfg,
   input wire ppClkCfg,
   input wire uart2ClkCfg,
   input wire uart1ClkCfg,
   input wire uart2Busy,
   input wire uart1Busy,
   input wire multStable,
   input wire pmTimerStatusIn,
   input wire pmTimerIrqEnIn,
   input wire keyboardIrq,
   input wire mouseIrq,
   input wire uart1Irq,
   input wire uart2Irq,
   output reg keyboard_clock_hiz,
   output reg keyboard_data_hiz,
   output reg mouse_clock_hiz,
   output reg mouse_data_hiz,
   output reg fdcHiz,
   output reg ppHiz,
   output reg uart2Hiz,
   output reg uart1Hiz,
   output reg [1:0] clockSource,
   output reg multEnable,
   output reg ppClkEn,
   output reg uart2ClkEn,
   output reg uart1ClkEn,
   output reg pmTimerClkEn,
   output reg pm_timer_status,
   output reg pm_timer_irq_enable,
   output reg timeout_out_n
);

reg [1:0] rstPipe;
wire rstSyncN;
reg [`INDEX_W-1:0] index;
reg [7:0] tristate_override;
reg [7:0] clock_source_control;
reg [7:0] function_clock_control;
reg [7:0] timeout_period;
reg [7:0] reload_trigger_enable;
reg strapTaken;
reg [7:0] countdown;
reg running;
wire minuteTick;
wire dataWr;
wire dataRd;
wire pmClear;
wire trigger;
reg [7:0] readMux;
wire indexWr;
wire restartPs;

////////////////////////////////////////////////////////////////////////////////
// Reset synchroniser
always @(posedge ref_clk or negedge resetn) begin
   if (!resetn) begin
      rstPipe <= 2'h0;
   end else begin
      rstPipe <= {rstPipe[0], 1'b1};
   end
end
assign rstSyncN = rstPipe[1];

////////////////////////////////////////////////////////////////////////////////
// Strobes
assign indexWr = busCs && busWr && (busAddr == `PORT_INDEX);
assign dataWr = busCs && busWr && (busAddr == `PORT_DATA);
assign dataRd = busCs && busRd && (busAddr == `PORT_DATA);
assign pmClear = softReset || pmActivate;

function isWrite;
   input [`INDEX_W-1:0] idx;
   begin
      isWrite = dataWr && (index == idx);
   end
endfunction

function floatCtl;
   input override;
   input devCfg;
   begin
      floatCtl = override | devCfg;
   end
endfunction

function gateCtl;
   input enable;
   input devCfg;
   begin
      gateCtl = enable & devCfg;
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Index register
always @(posedge ref_clk or negedge rstSyncN) begin
   if (!rstSyncN) begin
      index <= `RST_INDEX;
   end else if (indexWr) begin
      index <= busWrData[`INDEX_W-1:0];
   end
end

////////////////////////////////////////////////////////////////////////////////
// Control registers
always @(posedge ref_clk or negedge rstSyncN) begin
   if (!rstSyncN) begin
      tristate_override <= `RST_TRISTATE;
      function_clock_control <= `RST_FNCLK;
   end else begin
      if (isWrite(`IDX_TRISTATE)) begin
         tristate_override <= busWrData & `MASK_TRISTATE;
      end
      if (isWrite(`IDX_FNCLK)) begin
         function_clock_control <= busWrData & `MASK_FNCLK;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Clock source, strap taken once after reset
always @(posedge ref_clk or negedge rstSyncN) begin
   if (!rstSyncN) begin
      clock_source_control <= 8'h00;
      strapTaken <= 1'b0;
   end else if (!strapTaken) begin
      strapTaken <= 1'b1;
      clock_source_control[`CS_SRC_LO] <= ~clock_strap;
   end else if (isWrite(`IDX_CLKSRC)) begin
      clock_source_control <= busWrData & `MASK_CLKSRC;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Period and trigger enables
always @(posedge ref_clk or negedge rstSyncN) begin
   if (!rstSyncN) begin
      timeout_period <= `RST_PERIOD;
      reload_trigger_enable <= `RST_TRIGEN;
   end else if (pmClear) begin
      timeout_period <= `RST_PERIOD;
      reload_trigger_enable <= `RST_TRIGEN;
   end else begin
      if (isWrite(`IDX_PERIOD)) begin
         timeout_period <= busWrData;
      end
      if (isWrite(`IDX_TRIGEN)) begin
         reload_trigger_enable <= busWrData & `MASK_TRIGEN;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Trigger detection on active IRQ level
assign trigger = (reload_trigger_enable[`TE_KBD] && keyboardIrq)
   || (reload_trigger_enable[`TE_MOUSE] && mouseIrq)
   || (reload_trigger_enable[`TE_UART1] && uart1Irq)
   || (reload_trigger_enable[`TE_UART2] && uart2Irq);

////////////////////////////////////////////////////////////////////////////////
// Minute prescaler, restarted on every reload
assign restartPs = (dataWr && (index == `IDX_PERIOD)) || (running && trigger);
minute_prescaler #(
   .CNT_W(CNT_W),
   .TICKS(MINUTE_CYCLES)
) uPrescaler (
   .ref_clk(ref_clk),
   .rstSyncN(rstSyncN),
   .run(running),
   .restart(restartPs),
   .tick(minuteTick)
);

////////////////////////////////////////////////////////////////////////////////
// Countdown
always @(posedge ref_clk or negedge rstSyncN) begin
   if (!rstSyncN) begin
      countdown <= 8'h00;
      running <= 1'b0;
      timeout_out_n <= 1'b1;
   end else if (pmClear) begin
      countdown <= 8'h00;
      running <= 1'b0;
      timeout_out_n <= 1'b1;
   end else if (isWrite(`IDX_PERIOD)) begin
      countdown <= busWrData;
      running <= (busWrData != 8'h00);
      timeout_out_n <= 1'b1;
   end else if (running && trigger) begin
      countdown <= timeout_period;
   end else if (running && minuteTick) begin
      countdown <= countdown - 8'h01;
      if (countdown == 8'h01) begin
         running <= 1'b0;
         timeout_out_n <= 1'b0;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Registered float controls
always @(posedge ref_clk or negedge rstSyncN) begin
   if (!rstSyncN) begin
      keyboard_clock_hiz <= 1'b0;
      keyboard_data_hiz <= 1'b0;
      mouse_clock_hiz <= 1'b0;
      mouse_data_hiz <= 1'b0;
      fdcHiz <= 1'b0;
      ppHiz <= 1'b0;
      uart2Hiz <= 1'b0;
      uart1Hiz <= 1'b0;
   end else begin
      keyboard_clock_hiz <= floatCtl(tristate_override[`TS_KBD], kbdTriCfg);
      keyboard_data_hiz <= floatCtl(tristate_override[`TS_KBD], kbdTriCfg);
      mouse_clock_hiz <= floatCtl(tristate_override[`TS_KBD], kbdTriCfg);
      mouse_data_hiz <= floatCtl(tristate_override[`TS_KBD], kbdTriCfg);
      fdcHiz <= floatCtl(tristate_override[`TS_FDC], fdcTriCfg);
      ppHiz <= floatCtl(tristate_override[`TS_PP], ppTriCfg);
      uart2Hiz <= floatCtl(tristate_override[`TS_UART2], uart2TriCfg);
      uart1Hiz <= floatCtl(tristate_override[`TS_UART1], uart1TriCfg);
   end
end

////////////////////////////////////////////////////////////////////////////////
// Registered clock controls
always @(posedge ref_clk or negedge rstSyncN) begin
   if (!rstSyncN) begin
      clockSource <= `SRC_24M;
      multEnable <= 1'b0;
      ppClkEn <= 1'b0;
      uart2ClkEn <= 1'b0;
      uart1ClkEn <= 1'b0;
      pmTimerClkEn <= 1'b0;
      pm_timer_status <= 1'b0;
      pm_timer_irq_enable <= 1'b0;
   end else begin
      clockSource <= clock_source_control[`CS_SRC_HI:`CS_SRC_LO];
      multEnable <= clock_source_control[`CS_MULT_EN];
      ppClkEn <= gateCtl(function_clock_control[`FC_PP], ppClkCfg);
      uart2ClkEn <= gateCtl(function_clock_control[`FC_UART2], uart2ClkCfg);
      uart1ClkEn <= gateCtl(function_clock_control[`FC_UART1], uart1ClkCfg);
      pmTimerClkEn <= function_clock_control[`FC_TMR];
      pm_timer_status <= gateCtl(function_clock_control[`FC_TMR], pmTimerStatusIn);
      pm_timer_irq_enable <= gateCtl(function_clock_control[`FC_TMR], pmTimerIrqEnIn);
   end
end

////////////////////////////////////////////////////////////////////////////////
// Read mux
always @* begin
   readMux = 8'h00;
   case (index)
      `IDX_TRISTATE: begin
         readMux = tristate_override;
      end
      `IDX_CLKSRC: begin
         readMux = clock_source_control;
         readMux[`CS_MULT_OK] = multStable;
      end
      `IDX_FNCLK: begin
         readMux = function_clock_control;
         readMux[`FC_BUSY2] = uart2Busy;
         readMux[`FC_BUSY1] = uart1Busy;
      end
      `IDX_PERIOD: begin
         readMux = timeout_period;
      end
      `IDX_TRIGEN: begin
         readMux = reload_trigger_enable;
      end
      `IDX_WDSTAT: begin
         readMux[`WS_OUT] = timeout_out_n;
      end
      default: begin
         readMux = 8'h00;
      end
   endcase
end

////////////////////////////////////////////////////////////////////////////////
// Read data register, index bits above the index width read zero
always @(posedge ref_clk or negedge rstSyncN) begin
   if (!rstSyncN) begin
      busRdData <= 8'h00;
   end else if (dataRd) begin
      busRdData <= readMux;
   end else if (busCs && busRd) begin
      busRdData <= {3'h0, index};
   end
end

endmodule // pm_control_and_timeout_timer

// [pkg/pm_ctrl_regs.vh]
/*
 Register indexes, field positions, reset values and timing constants of the
 power-management control and time-out timer block.
 Assumes inclusion by bare name from the core files.
*/
`ifndef PM_CTRL_REGS_VH
`define PM_CTRL_REGS_VH

// Index and data port select
`define PORT_INDEX 1'b0
`define PORT_DATA 1'b1
`define INDEX_W 5

// Register indexes
`define IDX_TRISTATE 5'h02
`define IDX_CLKSRC 5'h03
`define IDX_FNCLK 5'h04
`define IDX_PERIOD 5'h05
`define IDX_TRIGEN 5'h06
`define IDX_WDSTAT 5'h07

// Reset values
`define RST_TRISTATE 8'h00
`define RST_FNCLK 8'h0E
`define RST_PERIOD 8'h00
`define RST_TRIGEN 8'h00
`define RST_INDEX 5'h00

// Writable masks
`define MASK_TRISTATE 8'h79
`define MASK_CLKSRC 8'h07
`define MASK_FNCLK 8'h0F
`define MASK_TRIGEN 8'h0F

// Override bits
`define TS_KBD 0
`define TS_FDC 3
`define TS_PP 4
`define TS_UART2 5
`define TS_UART1 6

// Clock source fields
`define CS_SRC_LO 0
`define CS_SRC_HI 1
`define CS_MULT_EN 2
`define CS_MULT_OK 7
`define SRC_24M 2'h0
`define SRC_RSVD 2'h1
`define SRC_48M 2'h2
`define SRC_MULT 2'h3

// Function clock fields
`define FC_TMR 0
`define FC_PP 1
`define FC_UART2 2
`define FC_UART1 3
`define FC_BUSY2 6
`define FC_BUSY1 7

// Trigger enable fields
`define TE_KBD 0
`define TE_MOUSE 1
`define TE_UART1 2
`define TE_UART2 3

// Time-out status bit
`define WS_OUT 0

// Timing
`define MINUTE_S 40'h0000_00003C
`define NS_PER_S 40'h00_3B9A_CA00
`define CLK_PERIOD_NS 40'h0000_00000A
`define MINUTE_CYCLES (`MINUTE_S * `NS_PER_S / `CLK_PERIOD_NS)

`endif

// [core/minute_prescaler.v]
/*
 Prescaler that turns the core clock into a one-cycle decrement enable.
 Assumes a synchronous active-high restart and the block's synchronised reset.
*/
module minute_prescaler #(
   parameter CNT_W = 40,
   parameter [CNT_W-1:0] TICKS = 40'h0000_00000A
) (
   input wire ref_clk,
   input wire rstSyncN,
   input wire run,
   input wire restart,
   output reg tick
);

reg [CNT_W-1:0] count;

////////////////////////////////////////////////////////////////////////////////
// Count up to TICKS, restart on reload
always @(posedge ref_clk or negedge rstSyncN) begin
   if (!rstSyncN) begin
      count <= {CNT_W{1'b0}};
      tick <= 1'b0;
   end else if (restart || !run) begin
      count <= {CNT_W{1'b0}};
      tick <= 1'b0;
   end else if (count == TICKS - {{(CNT_W-1){1'b0}}, 1'b1}) begin
      count <= {CNT_W{1'b0}};
      tick <= 1'b1;
   end else begin
      count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
      tick <= 1'b0;
   end
end

endmodule // minute_prescaler

// [tb/pm_timer_monitor.sv]
/*
 Port checker for the power-management control and time-out timer block.
 Assumes a bind onto the top module with its count parameters handed on.
*/
module pm_timer_monitor #(
   parameter CNT_W = 40,
   parameter [CNT_W-1:0] MINUTE_CYCLES = 40'h14
) (
   input wire ref_clk,
   input wire resetn,
   input wire softReset,
   input wire pmActivate,
   input wire busCs,
   input wire busRd,
   input wire busWr,
   input wire kbdTriCfg,
   input wire fdcTriCfg,
   input wire uart1TriCfg,
   input wire ppClkCfg,
   input wire [7:0] busRdData,
   input wire keyboard_clock_hiz,
   input wire keyboard_data_hiz,
   input wire mouse_clock_hiz,
   input wire mouse_data_hiz,
   input wire fdcHiz,
   input wire uart1Hiz,
   input wire ppClkEn,
   input wire pmTimerClkEn,
   input wire pm_timer_status,
   input wire pm_timer_irq_enable,
   input wire timeout_out_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] up;
   logic [CNT_W-1:0] hiCnt;
   // Settle time after reset, and length of the current inactive spell
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         up <= 3'h0;
         hiCnt <= '0;
      end else begin
         if (up != 3'h7) up <= up + 3'h1;
         hiCnt <= timeout_out_n ? hiCnt + 1'b1 : '0;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (up != 3'h7);
   kbd_float_a: assert property (kbdTriCfg |=> keyboard_clock_hiz && keyboard_data_hiz
      && mouse_clock_hiz && mouse_data_hiz) else $error("keyboard pins not floated");
   dev_float_a: assert property (fdcTriCfg && uart1TriCfg |=> fdcHiz && uart1Hiz)
      else $error("device pins not floated");
   clock_and_a: assert property (!ppClkCfg |=> !ppClkEn) else $error("clock gate open");
   timer_gate_a: assert property (!pmTimerClkEn |-> !pm_timer_status && !pm_timer_irq_enable)
      else $error("timer bits not zero");
   soft_release_a: assert property (softReset |-> ##[1:2] timeout_out_n)
      else $error("soft reset left output low");
   act_release_a: assert property (pmActivate |-> ##[1:2] timeout_out_n)
      else $error("activation left output low");
   timeout_hold_a: assert property (!timeout_out_n && !busWr && !softReset && !pmActivate
      |=> !timeout_out_n) else $error("time-out output released");
   minute_count_a: assert property ($fell(timeout_out_n) |-> hiCnt >= MINUTE_CYCLES - 1)
      else $error("time-out came early");
   read_stands_a: assert property (!(busCs && busRd) [*2] |=> $stable(busRdData))
      else $error("read data changed");
endmodule // pm_timer_monitor

bind pm_control_and_timeout_timer pm_timer_monitor #(
   .CNT_W(CNT_W),
   .MINUTE_CYCLES(MINUTE_CYCLES)
) mon_u (.*);

// [tb/power_down_model.sv]
/*
 Power-down logic that watches the time-out output.
 Assumes the bench clock and hard reset.
*/
module power_down_model (
   input wire ref_clk,
   input wire resetn,
   input wire timeout_out_n,
   output logic pwrDown
);
   timeunit 1ns;
   timeprecision 1ps;
   // Requests power-down while the time-out output is active
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pwrDown <= 1'b0;
      end else begin
         pwrDown <= !timeout_out_n;
      end
   end
endmodule // power_down_model

// [tb/pm_control_and_timeout_timer_bench.sv]
/*
 Self-checking bench: register accesses through the index/data pair.
 Assumes the design, its header and the checker are compiled first.
*/
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end

module pm_control_and_timeout_timer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MC = 20;
   logic ref_clk, resetn, softReset, pmActivate, clock_strap, busCs, busAddr, busRd, busWr;
   logic [7:0] busWrData, busRdData, rv;
   logic kbdTriCfg, fdcTriCfg, ppTriCfg, uart2TriCfg, uart1TriCfg, ppClkCfg, uart2ClkCfg;
   logic uart1ClkCfg, uart2Busy, uart1Busy, multStable, pmTimerStatusIn, pmTimerIrqEnIn;
   logic keyboard_clock_hiz, keyboard_data_hiz, mouse_clock_hiz, mouse_data_hiz;
   logic fdcHiz, ppHiz, uart2Hiz, uart1Hiz, multEnable, ppClkEn, uart2ClkEn, uart1ClkEn;
   logic pmTimerClkEn, pm_timer_status, pm_timer_irq_enable, timeout_out_n, pwrDown;
   logic [1:0] clockSource;
   logic [3:0] irq;
   logic [1:0] cs [3] = '{2'h0, 2'h2, 2'h3};
   wire keyboardIrq, mouseIrq, uart1Irq, uart2Irq;
   wire [7:0] hz = {keyboard_clock_hiz, keyboard_data_hiz, mouse_clock_hiz, mouse_data_hiz,
      fdcHiz, ppHiz, uart2Hiz, uart1Hiz};
   int err_total, n_tests;
   assign {uart2Irq, uart1Irq, mouseIrq, keyboardIrq} = irq;

   pm_control_and_timeout_timer #(.CNT_W(40), .MINUTE_CYCLES(40'h14)) dut_u (.*);
   power_down_model pd_u (.ref_clk(ref_clk), .resetn(resetn), .timeout_out_n(timeout_out_n),
      .pwrDown(pwrDown));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic cyc(int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic acc(logic a, logic w, logic [7:0] d);
      busCs = 1'b1;
      busAddr = a;
      busWr = w;
      busRd = !w;
      busWrData = d;
      cyc(1);
      busCs = 1'b0;
      busWr = 1'b0;
      busRd = 1'b0;
      cyc(1);
   endtask
   task automatic wr(logic [7:0] i, logic [7:0] d);
      acc(1'b0, 1'b1, i);
      acc(1'b1, 1'b1, d);
   endtask
   task automatic rchk(logic [7:0] i, logic [7:0] e);
      acc(1'b0, 1'b1, i);
      acc(1'b1, 1'b0, 8'h00);
      rv = busRdData;
      `CHK(rv, e)
   endtask
   task automatic hreset(logic s);
      resetn = 1'b0;
      clock_strap = s;
      cyc(16);
      resetn = 1'b1;
      cyc(4);
   endtask
   task automatic stop_test();
      $display("Counts: %0d mismatches in %0d comparisons", err_total, n_tests);
      if (err_total == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      #100us;
      err_total++;
      stop_test();
   end
   initial begin
      {softReset, pmActivate, busCs, busAddr, busRd, busWr, busWrData, irq} = '0;
      {kbdTriCfg, fdcTriCfg, ppTriCfg, uart2TriCfg, uart1TriCfg, ppClkCfg} = '0;
      {uart2ClkCfg, uart1ClkCfg, uart2Busy, uart1Busy, multStable} = '0;
      {pmTimerStatusIn, pmTimerIrqEnIn} = '0;
      hreset(1'b0);
      rchk(8'h02, 8'h00);
      rchk(8'h04, 8'h0E);
      rchk(8'h03, 8'h01);
      rchk(8'h06, 8'h00);
      rchk(8'h07, 8'h01);
      // Overrides, alone and ORed with the devices' own settings
      wr(8'h02, 8'hFF);
      `CHK(hz, 8'hFF)
      rchk(8'h02, 8'h79);
      wr(8'h02, 8'h00);
      {kbdTriCfg, uart1TriCfg} = 2'h3;
      cyc(2);
      `CHK(hz, 8'hF1)
      {kbdTriCfg, uart1TriCfg} = 2'h0;
      for (int i = 3; i < 7; i++) begin
         wr(8'h02, 8'h01 << i);
         `CHK(hz, 8'h08 >> (i - 3))
      end
      // Clock source codes and multiplier status
      multStable = 1'b1;
      foreach (cs[k]) begin
         wr(8'h03, {6'h01, cs[k]});
         `CHK({multEnable, clockSource}, {1'b1, cs[k]})
         rchk(8'h03, {6'h21, cs[k]});
      end
      wr(8'h03, 8'h00);
      `CHK(multEnable, 1'b0)
      // Function clocks, timer gating and busy flags
      {ppClkCfg, uart2ClkCfg, uart1ClkCfg, uart1Busy} = 4'hF;
      {pmTimerStatusIn, pmTimerIrqEnIn} = 2'h3;
      cyc(2);
      `CHK({ppClkEn, uart2ClkEn, uart1ClkEn, pmTimerClkEn, pm_timer_status}, 5'h1C)
      rchk(8'h04, 8'h8E);
      wr(8'h04, 8'h09);
      `CHK({ppClkEn, uart2ClkEn, uart1ClkEn, pmTimerClkEn, pm_timer_irq_enable}, 5'h07)
      `CHK(pm_timer_status, 1'b1)
      {uart1ClkCfg, uart2Busy, uart1Busy} = 3'h2;
      cyc(2);
      `CHK(uart1ClkEn, 1'b0)
      rchk(8'h04, 8'h49);
      // Countdown, expiry and release
      wr(8'h05, 8'h02);
      rchk(8'h05, 8'h02);
      cyc(MC);
      `CHK(timeout_out_n, 1'b1)
      cyc(MC);
      `CHK(timeout_out_n, 1'b0)
      `CHK(pwrDown, 1'b1)
      rchk(8'h07, 8'h00);
      cyc(2 * MC);
      `CHK(timeout_out_n, 1'b0)
      wr(8'h05, 8'h03);
      `CHK(timeout_out_n, 1'b1)
      wr(8'h05, 8'h00);
      cyc(4 * MC);
      `CHK(timeout_out_n, 1'b1)
      // Each trigger: others ignored, its own reloads
      for (int i = 0; i < 4; i++) begin
         wr(8'h06, 8'h01 << i);
         wr(8'h05, 8'h01);
         irq = ~(4'h1 << i);
         cyc(2 * MC);
         `CHK(timeout_out_n, 1'b0)
         wr(8'h05, 8'h01);
         irq = 4'h1 << i;
         cyc(3 * MC);
         `CHK(timeout_out_n, 1'b1)
         irq = 4'h0;
      end
      // Software reset and device activation clear the timer
      for (int k = 0; k < 2; k++) begin
         wr(8'h06, 8'h0F);
         wr(8'h05, 8'h01);
         cyc(2 * MC);
         {pmActivate, softReset} = 2'h1 << k;
         cyc(1);
         {pmActivate, softReset} = 2'h0;
         cyc(1);
         `CHK(timeout_out_n, 1'b1)
         rchk(8'h05, 8'h00);
         rchk(8'h06, 8'h00);
      end
      hreset(1'b1);
      rchk(8'h03, 8'h80);
      rchk(8'h02, 8'h00);
      stop_test();
   end
endmodule // pm_control_and_timeout_timer_bench
